// ---- verilog/asw_cfg.svh ----
// asw_cfg.svh: timing counts and widths for the host-side async sram controller.
// assumes a 25 MHz system clock (40 ns period) and the slowest speed grade figures.
//
// Function
// - host holds write address stable a full write cycle, 8/10/12 ns.
// - zero address setup; address valid 8/9/10 ns before write end.
// - host drives write data 4/5/6 ns before terminating edge; zero hold.
// - in select-ended write, select low at least 7/8/9 ns before end.
// - host avoids driving data lines while the memory drives them.
// - host keeps write strobe high throughout any read cycle.
`ifndef ASW_CFG_SVH
`define ASW_CFG_SVH

`define ASW_CLK_PERIOD_PS 40000
`define ASW_ADDR_W 15
`define ASW_DATA_W 8
// slowest grade figures, in ps
`define ASW_T_CYCLE_PS 12000
`define ASW_T_ADDR_END_PS 10000
`define ASW_T_DATA_END_PS 6000
`define ASW_T_SEL_END_PS 9000
`define ASW_T_RELEASE_PS 6000
`define ASW_T_ACCESS_PS 12000
// least times round up, none below one cycle
`define ASW_CYC(ps) (((ps) + `ASW_CLK_PERIOD_PS - 1) / `ASW_CLK_PERIOD_PS)
`define ASW_WR_CYC (`ASW_CYC(`ASW_T_ADDR_END_PS) > 1 ? `ASW_CYC(`ASW_T_ADDR_END_PS) : 1)
`define ASW_RD_CYC (`ASW_CYC(`ASW_T_ACCESS_PS) > 1 ? `ASW_CYC(`ASW_T_ACCESS_PS) : 1)
`define ASW_TURN_CYC (`ASW_CYC(`ASW_T_RELEASE_PS) > 1 ? `ASW_CYC(`ASW_T_RELEASE_PS) : 1)

`endif

// ---- verilog/asw_pkg.sv ----
// asw_pkg.sv: types for the host-side async sram controller.
// assumes asw_cfg.svh is on the include path.
`include "asw_cfg.svh"

package asw_pkg;
	typedef struct packed {
		logic write;
		logic [`ASW_ADDR_W-1:0] addr;
		logic [`ASW_DATA_W-1:0] wdata;
	} asw_req_t;

	typedef struct packed {
		logic chip_sel_n;
		logic wr_strobe_n;
		logic out_gate_n;
		logic [`ASW_ADDR_W-1:0] word_select_lines;
	} asw_pins_t;

	typedef enum logic [2:0] {
		ASW_IDLE,
		ASW_WR_PULSE,
		ASW_WR_END,
		ASW_RD_WAIT,
		ASW_TURN
	} asw_state_t;
endpackage

// ---- verilog/asw_host.sv ----
// asw_host.sv: host controller that drives an asynchronous 32K x 8 static memory.
// assumes requests come from logic on i_clk_sys and the memory pins are wired directly.
`timescale 1ns/1ps
`include "asw_cfg.svh"

module asw_host #(
	parameter int WR_CYC = `ASW_WR_CYC,
	parameter int RD_CYC = `ASW_RD_CYC,
	parameter int TURN_CYC = `ASW_TURN_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire asw_pkg::asw_req_t i_req,
	output logic o_rd_valid,
	output logic [`ASW_DATA_W-1:0] o_rd_data,
	output asw_pkg::asw_pins_t o_pins,
	input wire logic [`ASW_DATA_W-1:0] i_data_lines,
	output logic [`ASW_DATA_W-1:0] o_data_lines,
	output logic o_data_lines_oe_n
);
	import asw_pkg::*;

	// ==========================================================
	// reset release
	logic rst_meta_r;
	logic rst_sync_r;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ==========================================================
	// data line input synchroniser
	// read data is sampled only after the access time has passed, so the two stages add latency only
	logic [`ASW_DATA_W-1:0] din_meta_r;
	logic [`ASW_DATA_W-1:0] din_sync_r;
	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			din_meta_r <= '0;
			din_sync_r <= '0;
		end else begin
			din_meta_r <= i_data_lines;
			din_sync_r <= din_meta_r;
		end
	end

	// ==========================================================
	// sequencer
	asw_state_t state_r;
	asw_state_t state_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	asw_pins_t pins_r;
	asw_pins_t pins_nxt;
	logic [`ASW_DATA_W-1:0] wdata_r;
	logic [`ASW_DATA_W-1:0] wdata_nxt;
	logic drive_r;
	logic drive_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic [`ASW_DATA_W-1:0] rd_data_r;
	logic [`ASW_DATA_W-1:0] rd_data_nxt;

	wire logic cnt_done = (cnt_r == 8'h00);
	wire logic idle = (state_r == ASW_IDLE);
	// two sync stages delay the read sample; wait for them before select and output gate rise
	localparam logic [7:0] RD_LOAD = 8'(RD_CYC + 1);
	localparam logic [7:0] WR_LOAD = 8'(WR_CYC - 1);
	localparam logic [7:0] TURN_LOAD = 8'(TURN_CYC - 1);
	localparam logic [7:0] SYNC_LAT = 8'h02;

	// ==========================================================
	// event decode
	// each conditional sequencer step is named here (the ASW_WR_END exit is unconditional) so the case below only steers
	wire logic take = idle && i_req_valid;
	wire logic wr_take = take && i_req.write;
	wire logic rd_take = take && !i_req.write;
	wire logic wr_pulse_done = (state_r == ASW_WR_PULSE) && cnt_done;
	wire logic rd_wait_done = (state_r == ASW_RD_WAIT) && cnt_done;
	wire logic turn_done = (state_r == ASW_TURN) && cnt_done;

	assign o_req_ready = idle;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		pins_nxt = pins_r;
		wdata_nxt = wdata_r;
		drive_nxt = drive_r;
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		if (!cnt_done) begin
			cnt_nxt = cnt_r - 8'h01;
		end
		case (state_r)
			ASW_IDLE: begin
				if (take) begin
					// address, select and strobe move together: zero setup
					pins_nxt.word_select_lines = i_req.addr;
					pins_nxt.chip_sel_n = 1'b0;
					if (wr_take) begin
						// select falls with the strobe so memory outputs stay off
						pins_nxt.wr_strobe_n = 1'b0;
						pins_nxt.out_gate_n = 1'b1;
						wdata_nxt = i_req.wdata;
						drive_nxt = 1'b1;
						cnt_nxt = WR_LOAD;
						state_nxt = ASW_WR_PULSE;
					end else if (rd_take) begin
						pins_nxt.wr_strobe_n = 1'b1;
						pins_nxt.out_gate_n = 1'b0;
						drive_nxt = 1'b0;
						cnt_nxt = RD_LOAD + SYNC_LAT;
						state_nxt = ASW_RD_WAIT;
					end
				end
			end
			ASW_WR_PULSE: begin
				// address, data and select held over the whole pulse
				if (wr_pulse_done) begin
					// select and strobe rise together, ending the write; data held one more cycle
					pins_nxt.chip_sel_n = 1'b1;
					pins_nxt.wr_strobe_n = 1'b1;
					state_nxt = ASW_WR_END;
				end
			end
			ASW_WR_END: begin
				// zero hold is allowed, but releasing one cycle later costs little
				drive_nxt = 1'b0;
				cnt_nxt = TURN_LOAD;
				state_nxt = ASW_TURN;
			end
			ASW_RD_WAIT: begin
				if (rd_wait_done) begin
					rd_data_nxt = din_sync_r;
					rd_valid_nxt = 1'b1;
					pins_nxt.chip_sel_n = 1'b1;
					pins_nxt.out_gate_n = 1'b1;
					cnt_nxt = TURN_LOAD;
					state_nxt = ASW_TURN;
				end
			end
			ASW_TURN: begin
				// memory release time passes before anyone may drive again
				if (turn_done) begin
					state_nxt = ASW_IDLE;
				end
			end
			default: begin
				state_nxt = ASW_IDLE;
			end
		endcase
	end

	// ==========================================================
	// registers
	// one short block per group keeps each reset value next to its register
	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			state_r <= ASW_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// strobes come up deasserted so the memory sees no write while reset lasts
	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pins_r <= '{chip_sel_n: 1'b1, wr_strobe_n: 1'b1, out_gate_n: 1'b1, word_select_lines: '0};
		end else begin
			pins_r <= pins_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			wdata_r <= '0;
		end else begin
			wdata_r <= wdata_nxt;
		end
	end

	// data lines stay released in reset so nothing fights the memory
	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			drive_r <= 1'b0;
		end else begin
			drive_r <= drive_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_valid_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign o_pins = pins_r;
	assign o_data_lines = wdata_r;
	assign o_data_lines_oe_n = ~drive_r;
	assign o_rd_valid = rd_valid_r;
	assign o_rd_data = rd_data_r;
endmodule // asw_host

// ---- test/asw_host_checker.sv ----
// asw_host_checker.sv: pin timing checks for asw_host.
// assumes it is bound into asw_host and sees only its ports.
`timescale 1ns/1ps
module asw_host_checker (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire logic o_req_ready,
	input wire asw_pkg::asw_req_t i_req,
	input wire asw_pkg::asw_pins_t o_pins,
	input wire logic [7:0] o_data_lines,
	input wire logic o_data_lines_oe_n
);
	// ==========
	// checks
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	wire take = i_req_valid && o_req_ready;
	wr_start_a: assert property (take && i_req.write |=> !o_pins.wr_strobe_n && !o_data_lines_oe_n
		&& o_data_lines == $past(i_req.wdata)) else $error("write start wrong");
	addr_start_a: assert property (take |=> o_pins.word_select_lines == $past(i_req.addr))
		else $error("address not presented");
	addr_hold_a: assert property ($fell(o_pins.chip_sel_n) |=> $stable(o_pins.word_select_lines))
		else $error("address moved");
	data_end_a: assert property ($rose(o_pins.wr_strobe_n) |-> !o_data_lines_oe_n && $stable(o_data_lines))
		else $error("data gone at write end");
	sel_cover_a: assert property (!o_pins.wr_strobe_n |-> !o_pins.chip_sel_n)
		else $error("strobe without select");
	no_fight_a: assert property (!o_data_lines_oe_n |-> o_pins.out_gate_n)
		else $error("both drive data");
	read_wr_a: assert property (!o_pins.out_gate_n |-> o_pins.wr_strobe_n)
		else $error("strobe low in read");
endmodule // asw_host_checker

bind asw_host asw_host_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
	.o_req_ready(o_req_ready), .i_req(i_req), .o_pins(o_pins), .o_data_lines(o_data_lines),
	.o_data_lines_oe_n(o_data_lines_oe_n));

// ---- test/asw_sram_model.sv ----
// asw_sram_model.sv: behavioural 32K x 8 async memory.
// assumes the host pins are wired straight in; no pull on data.
`timescale 1ns/1ps
module asw_sram_model (
	input wire asw_pkg::asw_pins_t i_pins,
	input wire logic [7:0] i_host_data,
	input wire logic i_host_oe_n,
	output logic [7:0] o_wire
);
	// ==========
	// storage
	logic [7:0] mem [0:32767];
	logic [7:0] last = 8'h00;
	wire wr_on = !i_pins.chip_sel_n && !i_pins.wr_strobe_n;
	wire drv = !i_pins.chip_sel_n && !i_pins.out_gate_n && i_pins.wr_strobe_n;
	always @(negedge wr_on) mem[i_pins.word_select_lines] = i_host_data;
	// a floating line shows the inverse of its last level
	assign o_wire = !i_host_oe_n ? i_host_data : drv ? mem[i_pins.word_select_lines] : ~last;
	always @(o_wire) if (!i_host_oe_n || drv) last = o_wire;
endmodule // asw_sram_model

// ---- test/test_asw_host.sv ----
// test_asw_host.sv: self-checking bench for asw_host.
// assumes package, model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, s); end end
module test_asw_host;
	import asw_pkg::*;
	logic i_clk_sys = 0;
	logic i_rst_n = 0;
	logic vld = 0;
	asw_req_t req = '0;
	logic rdy, rd_v, oe_n;
	logic [7:0] rd_d, hd, wd, v;
	asw_pins_t pins;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	asw_host dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req_valid(vld), .o_req_ready(rdy), .i_req(req),
		.o_rd_valid(rd_v), .o_rd_data(rd_d), .o_pins(pins), .i_data_lines(wd), .o_data_lines(hd),
		.o_data_lines_oe_n(oe_n));
	asw_sram_model mem (.i_pins(pins), .i_host_data(hd), .i_host_oe_n(oe_n), .o_wire(wd));
	initial forever #20 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 400) begin
			num_errors++;
			stop_test();
		end
	end
	// ==========
	// tasks
	task automatic stop_test();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// valid stays up so back-to-back requests never toggle it
	task automatic send(input logic w, input logic [14:0] a, input logic [7:0] d);
		vld = 1;
		req = {w, a, d};
		while (rdy !== 1'b1) @(posedge i_clk_sys) #1;
		@(posedge i_clk_sys) #1;
	endtask
	task automatic rd(input logic [14:0] a);
		send(1'b0, a, 8'h00);
		vld = 0;
		while (rd_v !== 1'b1) @(posedge i_clk_sys) #1;
		v = rd_d;
	endtask
	task automatic t_idle();
		`CHK("sel_n", 1'b1, pins.chip_sel_n)
		`CHK("oe_n", 1'b1, oe_n)
		`CHK("wr_n", 1'b1, pins.wr_strobe_n)
		`CHK("ready", 1'b1, rdy)
	endtask
	task automatic t_b2b();
		send(1'b1, 15'h7fff, 8'ha5);
		send(1'b1, 15'h0000, 8'h5a);
		`CHK("cell", 8'ha5, mem.mem[15'h7fff])
		rd(15'h7fff);
		`CHK("rd_hi", 8'ha5, v)
		rd(15'h0000);
		`CHK("rd_lo", 8'h5a, v)
	endtask
	task automatic t_over();
		send(1'b1, 15'h7fff, 8'h3c);
		rd(15'h7fff);
		`CHK("rd_new", 8'h3c, v)
		`CHK("oe_n", 1'b1, oe_n)
	endtask
	initial begin
		repeat (4) @(posedge i_clk_sys);
		#1 i_rst_n = 1;
		repeat (3) @(posedge i_clk_sys) #1;
		t_idle();
		t_b2b();
		t_over();
		stop_test();
	end
endmodule // test_asw_host
